// ==== mit_pkg.sv ====
// mit_pkg: constants, types and helpers for the message interrupt translation block.
// assumes a single clock domain; all table sizes are small on-chip arrays.
package mit_pkg;

  localparam int DEV_W    = 2;
  localparam int EV_W     = 2;
  localparam int LPI_W    = 4;
  localparam int COLL_W   = 2;
  localparam int RTR_W    = 1;
  localparam int NUM_DEV  = 4;
  localparam int NUM_EV   = 4;
  localparam int NUM_LPI  = 16;
  localparam int NUM_COLL = 4;
  localparam int NUM_RTR  = 2;
  localparam int ADDR_W   = 12;
  localparam int QPTR_W   = 3;
  localparam int QWORD_W  = 3;

  localparam logic [31:0] LPI_FIRST      = 32'h0000_2000;
  localparam int          CMD_BYTES      = 32;
  localparam int          CMD_WORDS      = CMD_BYTES / 4;
  localparam logic [2:0]  FETCH_LAST     = 3'h4;
  localparam logic [2:0]  FETCH_DONE     = 3'h5;
  localparam logic [31:0] RTR_ADDR_BASE  = 32'h1000_0000;
  localparam int          RTR_ADDR_SHIFT = 17;

  localparam logic [ADDR_W-1:0] REG_CTRL      = 12'h000;
  localparam logic [ADDR_W-1:0] REG_CFG_BASE  = 12'h004;
  localparam logic [ADDR_W-1:0] REG_PEND_BASE = 12'h008;
  localparam logic [ADDR_W-1:0] REG_CMD_WR    = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_CMD_RD    = 12'h010;
  localparam logic [ADDR_W-1:0] REG_INV_ONE   = 12'h014;
  localparam logic [ADDR_W-1:0] REG_INV_ALL   = 12'h018;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 12'h01C;
  localparam logic [1:0]        WIN_QUEUE     = 2'h1;
  localparam logic [1:0]        WIN_CFG       = 2'h2;

  localparam int         CTRL_EN_BIT   = 0;
  localparam int         CTRL_MODE_BIT = 1;
  localparam int         CFG_EN_BIT    = 0;
  localparam int         CFG_RSV_BIT   = 1;
  localparam int         CFG_PRIO_LSB  = 2;
  localparam logic [4:0] IDW_RESET     = 5'h0D;
  localparam logic [31:0] BASE_RESET   = 32'h0000_0000;

  typedef enum logic [7:0] {
    OP_DEV_MAP   = 8'h01, OP_IDENT_MAP = 8'h02, OP_XLAT_MAP = 8'h03,
    OP_COLL_MAP  = 8'h04, OP_MOVE_ALL  = 8'h05, OP_MOVE_INT = 8'h06,
    OP_DISCARD   = 8'h07, OP_INV_ONE   = 8'h08, OP_INV_COLL = 8'h09,
    OP_SYNC      = 8'h0A
  } mit_op_t;

  typedef struct packed {
    logic            valid;
    logic [DEV_W-1:0] dev;
    logic [EV_W-1:0]  evt;
  } mit_event_t;

  typedef struct packed {
    logic              valid;
    logic [LPI_W-1:0]  message_interrupt;
    logic [COLL_W-1:0] coll;
  } mit_itt_t;

  // target naming follows the address mode flag
  function automatic logic [RTR_W-1:0] mitRouterOf(input logic [31:0] tgt, input logic addrMode);
    logic [31:0] off;
    off = tgt - RTR_ADDR_BASE;
    if (addrMode)
      return off[RTR_ADDR_SHIFT +: RTR_W];
    return tgt[RTR_W-1:0];
  endfunction : mitRouterOf

  // true when the number is a message interrupt inside the programmed id width and the table of NUM_LPI entries
  function automatic logic mitIdOk(input logic [31:0] id, input logic [4:0] idw);
    logic [32:0] lim;
    logic [31:0] off;
    lim = 33'h1 << (6'(idw) + 6'h1);
    off = id - LPI_FIRST;
    return (id >= LPI_FIRST) && ({1'b0, id} < lim) && (off < 32'(NUM_LPI));
  endfunction : mitIdOk

endpackage : mit_pkg

// ==== mit_cmd_mem.sv ====
// mit_cmd_mem: command queue storage, one write port and one registered read port.
// assumes the writer and the reader share the clock; read data follow the address by one cycle.
`timescale 1ns/1ps
module mit_cmd_mem
  import mit_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 64,
  parameter int AW    = 6
)(
  input  wire logic             clk,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData_q
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
    rdData_q <= mem[rdAddr];
  end
endmodule : mit_cmd_mem

// ==== mit_prio_select.sv ====
// mit_prio_select: picks the highest priority enabled pending interrupt of one router.
// assumes a lower priority value wins and ties go to the lower number.
`timescale 1ns/1ps
module mit_prio_select
  import mit_pkg::*;
#(
  parameter int N = NUM_LPI
)(
  input  wire logic                clk,
  input  wire logic                rstN,
  input  wire logic                enable,
  input  wire logic [N-1:0]        pend,
  input  wire logic [N-1:0][7:0]   cfg,
  output logic                     bestValid_q,
  output logic      [31:0]         bestId_q,
  output logic      [7:0]          bestPrio_q
);
  logic        bestValid_d;
  logic [31:0] bestId_d;
  logic [7:0]  bestPrio_d;

  always_comb
  begin
    bestValid_d = 1'b0;
    bestId_d    = 32'h0000_0000;
    bestPrio_d  = 8'hFF;
    for (int i = 0; i < N; i++)
    begin
      if (enable && pend[i] && cfg[i][CFG_EN_BIT] && (!bestValid_d || {cfg[i][7:2], 2'b00} < bestPrio_d))
      begin
        bestValid_d = 1'b1;
        bestId_d    = LPI_FIRST + 32'(i);
        bestPrio_d  = {cfg[i][7:CFG_PRIO_LSB], 2'b00};
      end
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      bestValid_q <= 1'b0;
      bestId_q    <= 32'h0000_0000;
      bestPrio_q  <= 8'h00;
    end
    else
    begin
      bestValid_q <= bestValid_d;
      bestId_q    <= bestId_d;
      bestPrio_q  <= bestPrio_d;
    end
  end

  a_prio_low_zero : assert property (@(posedge clk) disable iff (!rstN)
    bestValid_q |-> bestPrio_q[1:0] == 2'b00) else $error("priority low bits not zero");
endmodule : mit_prio_select

// ==== mit_translate_top.sv ====
// mit_translate_top: command driven translation of device events into message interrupts,
// with per-router pending state, configuration cache and highest priority selection.
// assumes peripherals present events synchronously and routers acknowledge by interrupt number.
// Operation
// - device map binds device to translation table
// - identity map: interrupt equals event number (here event numbers 0-3 fail the id check, so nothing is mapped)
// - translated map stores explicit interrupt number
// - collection map replaces collection target router
// - mode flag: processor number or address
// - move all shifts pending old to new
// - move interrupt changes its collection
// - discard deletes mapping, clears its pending
// - after sync, removed mapping never delivers
// - device map with valid zero unmaps
// - bases read-only once enable set
// - config byte: priority, reserved zero, enable
// - priority low two bits forced zero
// - always Non-secure Group 1
// - numbers above 8191, indexed minus 8192
// - id width field limits interrupt range
// - configuration table is never written
// - one pending bit, acknowledge clears it
// - low pending area kept for own state
// - cache best pending, write back state (here pending bits stay on chip and are never written back)
// - invalidate one or whole collection cache
// - invalidate registers also drop cached config
// - 32-byte entries, full at one behind
// - commands consumed in queue order
`timescale 1ns/1ps
module mit_translate_top
  import mit_pkg::*;
#(
  parameter int QDEPTH = 8
)(
  input  wire logic                            clk,
  input  wire logic                            nrst,
  input  wire logic [ADDR_W-1:0]               busAddr,
  input  wire logic [31:0]                     busWrData,
  input  wire logic                            busWr,
  input  wire logic                            busRd,
  output logic      [31:0]                     busRdData_q,
  input  wire mit_event_t                      evIn,
  input  wire logic [NUM_RTR-1:0]              ackValid,
  input  wire logic [31:0]                     ackId,
  output logic      [NUM_RTR-1:0]            irqValid_q,
  output logic      [NUM_RTR-1:0][31:0]      irqId_q,
  output logic      [NUM_RTR-1:0][7:0]       irqPrio_q,
  output logic                               irqNsGroup1_q
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_EXEC = 2'b10} mit_state_t;

  logic [1:0]  rstSync_q;
  logic        rstN;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];

  // software visible state
  logic                     enable_q, enable_d, mode_q, mode_d;
  logic [31:0]              cfgBase_q, cfgBase_d, pendBase_q, pendBase_d;
  logic [QPTR_W-1:0]        wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [NUM_LPI-1:0][7:0]  cfgMem_q, cfgMem_d;
  logic [31:0]              rdData_d;
  logic [4:0]               idw;
  logic                     qFull, qPend;
  assign idw   = cfgBase_q[4:0];
  assign qFull = (wrPtr_q + QPTR_W'(1)) == rdPtr_q;
  assign qPend = wrPtr_q != rdPtr_q;

  // translation tables and router state
  logic [NUM_DEV-1:0]                 devValid_q, devValid_d;
  logic [NUM_DEV-1:0][31:0]           ittAddr_q, ittAddr_d;
  mit_itt_t [NUM_DEV*NUM_EV-1:0]      itt_q, itt_d;
  logic [NUM_COLL-1:0][RTR_W-1:0]     collTgt_q, collTgt_d;
  logic [NUM_RTR-1:0][NUM_LPI-1:0]    pend_q, pend_d;
  logic [NUM_LPI-1:0]                 cacheVal_q, cacheVal_d;
  logic [NUM_LPI-1:0][7:0]            cache_q, cache_d, cfgEff;

  // command engine
  mit_state_t                 state_q, state_d;
  logic [2:0]                 fetchIdx_q, fetchIdx_d, capIdx_q;
  logic                       capValid_q;
  logic [4:0][31:0]           cmdW_q, cmdW_d;
  logic [31:0]                memRdData;
  logic                       memWr;

  assign memWr = busWr && busAddr[11:10] == WIN_QUEUE;

  mit_cmd_mem #(.WIDTH(32), .DEPTH(QDEPTH * CMD_WORDS), .AW(QPTR_W + QWORD_W)) uCmdMem (
    .clk      (clk),
    .wrEn     (memWr),
    .wrAddr   (busAddr[2 +: QPTR_W + QWORD_W]),
    .wrData   (busWrData),
    .rdAddr   ({rdPtr_q, fetchIdx_q}),
    .rdData_q (memRdData)
  );

  // cached config wins; table is only read here
  for (genvar g = 0; g < NUM_LPI; g++)
  begin : gEff
    assign cfgEff[g] = cacheVal_q[g] ? cache_q[g] : cfgMem_q[g];
  end

  for (genvar r = 0; r < NUM_RTR; r++)
  begin : gRtr
    // selection is the router's cache of its best pending interrupt; pending bits stay
    // on chip, so no overflow or power-down write back is ever needed
    mit_prio_select #(.N(NUM_LPI)) uSel (
      .clk         (clk),
      .rstN        (rstN),
      .enable      (enable_q),
      .pend        (pend_q[r]),
      .cfg         (cfgEff),
      .bestValid_q (irqValid_q[r]),
      .bestId_q    (irqId_q[r]),
      .bestPrio_q  (irqPrio_q[r])
    );
  end

  // register port
  always_comb
  begin
    enable_d   = enable_q;
    mode_d     = mode_q;
    cfgBase_d  = cfgBase_q;
    pendBase_d = pendBase_q;
    wrPtr_d    = wrPtr_q;
    cfgMem_d   = cfgMem_q;
    rdData_d   = 32'h0000_0000;
    if (busWr)
    begin
      if (busAddr[11:10] == WIN_CFG)
      begin
        cfgMem_d[busAddr[2 +: LPI_W]]              = busWrData[7:0];
        cfgMem_d[busAddr[2 +: LPI_W]][CFG_RSV_BIT] = 1'b0;
      end
      unique case (busAddr)
        REG_CTRL:
        begin
          enable_d = busWrData[CTRL_EN_BIT];
          mode_d   = busWrData[CTRL_MODE_BIT];
        end
        REG_CFG_BASE:  if (!enable_q) cfgBase_d = busWrData;
        REG_PEND_BASE: if (!enable_q) pendBase_d = {busWrData[31:10], 10'h000};
        REG_CMD_WR:    wrPtr_d = busWrData[QPTR_W-1:0];
        default: ;
      endcase
    end
    if (busRd)
    begin
      unique case (busAddr)
        REG_CTRL:      rdData_d = {30'h0, mode_q, enable_q};
        REG_CFG_BASE:  rdData_d = cfgBase_q;
        REG_PEND_BASE: rdData_d = pendBase_q;
        REG_CMD_WR:    rdData_d = 32'(wrPtr_q);
        REG_CMD_RD:    rdData_d = 32'(rdPtr_q);
        REG_STATUS:    rdData_d = {30'h0, qFull, state_q != ST_IDLE};
        default:       rdData_d = (busAddr[11:10] == WIN_CFG) ? {24'h0, cfgMem_q[busAddr[2 +: LPI_W]]}
                                                              : 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      enable_q      <= 1'b0;
      mode_q        <= 1'b0;
      cfgBase_q     <= {BASE_RESET[31:5], IDW_RESET};
      pendBase_q    <= BASE_RESET;
      wrPtr_q       <= '0;
      cfgMem_q      <= '0;
      busRdData_q   <= 32'h0000_0000;
      irqNsGroup1_q <= 1'b0;
    end
    else
    begin
      enable_q      <= enable_d;
      mode_q        <= mode_d;
      cfgBase_q     <= cfgBase_d;
      pendBase_q    <= pendBase_d;
      wrPtr_q       <= wrPtr_d;
      cfgMem_q      <= cfgMem_d;
      busRdData_q   <= rdData_d;
      irqNsGroup1_q <= 1'b1;
    end
  end

  // command engine and tables
  logic [DEV_W-1:0]  cDev;
  logic [EV_W-1:0]   cEvt;
  logic [31:0]       cId;
  logic [COLL_W-1:0] cColl;
  logic [RTR_W-1:0]  cOld, cNew;
  logic              exec;
  mit_op_t           cOp;
  logic [DEV_W+EV_W-1:0] kProbe;
  assign cDev  = cmdW_q[0][8 +: DEV_W];
  assign cEvt  = cmdW_q[0][16 +: EV_W];
  assign cId   = cmdW_q[1];
  assign cColl = cmdW_q[2][COLL_W-1:0];
  assign cOld  = mitRouterOf(cmdW_q[3], mode_q);
  assign cNew  = mitRouterOf(cmdW_q[4], mode_q);
  assign cOp   = mit_op_t'(cmdW_q[0][7:0]);
  assign exec  = state_q == ST_EXEC;
  // assertions cannot see the key local to the process below
  assign kProbe = {cDev, cEvt};

  always_comb
  begin
    mit_itt_t   e;
    logic [DEV_W+EV_W-1:0] k, ek;
    logic [31:0] identId;
    logic [RTR_W-1:0] t;
    e          = '0;
    k          = {cDev, cEvt};
    ek         = {evIn.dev, evIn.evt};
    identId    = 32'(cEvt);
    t          = '0;
    state_d    = state_q;
    fetchIdx_d = fetchIdx_q;
    rdPtr_d    = rdPtr_q;
    cmdW_d     = cmdW_q;
    devValid_d = devValid_q;
    ittAddr_d  = ittAddr_q;
    itt_d      = itt_q;
    collTgt_d  = collTgt_q;
    pend_d     = pend_q;
    cacheVal_d = cacheVal_q;
    cache_d    = cache_q;
    if (capValid_q)
      cmdW_d[capIdx_q] = memRdData;
    unique case (state_q)
      ST_IDLE:
        if (qPend)
        begin
          state_d    = ST_FETCH;
          fetchIdx_d = 3'h0;
        end
      ST_FETCH:
      begin
        if (fetchIdx_q != FETCH_DONE)
          fetchIdx_d = fetchIdx_q + 3'h1;
        if (capValid_q && capIdx_q == FETCH_LAST)
          state_d = ST_EXEC;
      end
      ST_EXEC:
      begin
        state_d = ST_IDLE;
        rdPtr_d = rdPtr_q + QPTR_W'(1);
        unique case (cOp)
          OP_DEV_MAP:
          begin
            devValid_d[cDev] = cmdW_q[0][31];
            ittAddr_d[cDev]  = cmdW_q[0][31] ? cmdW_q[3] : 32'h0000_0000;
          end
          OP_IDENT_MAP:
            if (mitIdOk(identId, idw))
              itt_d[k] = '{valid: 1'b1, message_interrupt: LPI_W'(identId - LPI_FIRST), coll: cColl};
          OP_XLAT_MAP:
            if (mitIdOk(cId, idw))
              itt_d[k] = '{valid: 1'b1, message_interrupt: LPI_W'(cId - LPI_FIRST), coll: cColl};
          OP_COLL_MAP: collTgt_d[cColl] = cOld;
          OP_MOVE_ALL:
            if (cOld != cNew)
            begin
              pend_d[cNew] = pend_q[cNew] | pend_q[cOld];
              pend_d[cOld] = '0;
            end
          OP_MOVE_INT:
            if (itt_q[k].valid)
            begin
              e = itt_q[k];
              t = collTgt_q[cColl];
              if (pend_q[collTgt_q[e.coll]][e.message_interrupt])
              begin
                pend_d[collTgt_q[e.coll]][e.message_interrupt] = 1'b0;
                pend_d[t][e.message_interrupt]                 = 1'b1;
              end
              itt_d[k].coll = cColl;
            end
          OP_DISCARD:
            if (itt_q[k].valid)
            begin
              e = itt_q[k];
              itt_d[k].valid = 1'b0;
              for (int r = 0; r < NUM_RTR; r++)
                pend_d[r][e.message_interrupt] = 1'b0;
            end
          OP_INV_ONE:
            if (itt_q[k].valid)
              cacheVal_d[itt_q[k].message_interrupt] = 1'b0;
          OP_INV_COLL:
            for (int i = 0; i < NUM_DEV*NUM_EV; i++)
              if (itt_q[i].valid && itt_q[i].coll == cColl)
                cacheVal_d[itt_q[i].message_interrupt] = 1'b0;
          OP_SYNC: ;  // effects land in the exec cycle, so sync completes at once
          default: ;
        endcase
      end
      default: state_d = ST_IDLE;
    endcase
    // register invalidates, used where no command path is programmed
    if (busWr && busAddr == REG_INV_ONE && mitIdOk(busWrData, idw))
      cacheVal_d[LPI_W'(busWrData - LPI_FIRST)] = 1'b0;
    if (busWr && busAddr == REG_INV_ALL)
      cacheVal_d = '0;
    for (int r = 0; r < NUM_RTR; r++)
      if (ackValid[r] && mitIdOk(ackId, idw))
        pend_d[r][LPI_W'(ackId - LPI_FIRST)] = 1'b0;
    // event delivery last, so a set in the clearing cycle wins, except an event on the mapping being discarded
    if (evIn.valid && devValid_q[evIn.dev] && itt_q[ek].valid && enable_q)
    begin
      e = itt_q[ek];
      if (!(exec && cOp == OP_DISCARD && k == ek))
      begin
        pend_d[collTgt_d[e.coll]][e.message_interrupt] = 1'b1;
        if (!cacheVal_q[e.message_interrupt])
        begin
          cacheVal_d[e.message_interrupt] = 1'b1;
          cache_d[e.message_interrupt]    = cfgMem_q[e.message_interrupt];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_q    <= ST_IDLE;
      fetchIdx_q <= 3'h0;
      capIdx_q   <= 3'h0;
      capValid_q <= 1'b0;
      rdPtr_q    <= '0;
      cmdW_q     <= '0;
      devValid_q <= '0;
      ittAddr_q  <= '0;
      itt_q      <= '0;
      collTgt_q  <= '0;
      pend_q     <= '0;
      cacheVal_q <= '0;
      cache_q    <= '0;
    end
    else
    begin
      state_q    <= state_d;
      fetchIdx_q <= fetchIdx_d;
      capIdx_q   <= fetchIdx_q;
      capValid_q <= state_q == ST_FETCH && fetchIdx_q != FETCH_DONE;
      rdPtr_q    <= rdPtr_d;
      cmdW_q     <= cmdW_d;
      devValid_q <= devValid_d;
      ittAddr_q  <= ittAddr_d;
      itt_q      <= itt_d;
      collTgt_q  <= collTgt_d;
      pend_q     <= pend_d;
      cacheVal_q <= cacheVal_d;
      cache_q    <= cache_d;
    end
  end

  sequence sFetch;
    state_q == ST_FETCH [*6];
  endsequence
  sequence sRetire;
    state_q == ST_EXEC ##1 state_q == ST_IDLE;
  endsequence
  a_cmd_order_seq : assert property (@(posedge clk) disable iff (!rstN)
    state_q == ST_IDLE && qPend |=> sFetch ##1 sRetire) else $error("command fetch sequence broken");
  a_rdptr_step : assert property (@(posedge clk) disable iff (!rstN)
    rdPtr_q != $past(rdPtr_q) |-> rdPtr_q == $past(rdPtr_q) + QPTR_W'(1) && $past(exec)) else $error("read pointer jumped");
  a_base_locked : assert property (@(posedge clk) disable iff (!rstN)
    enable_q && busWr && busAddr == REG_CFG_BASE |=> $stable(cfgBase_q)) else $error("base changed while enabled");
  a_cfg_readonly : assert property (@(posedge clk) disable iff (!rstN)
    !$stable(cfgMem_q) |-> $past(busWr) && $past(busAddr[11:10]) == WIN_CFG) else $error("config table written by hardware");
  a_dev_unmap : assert property (@(posedge clk) disable iff (!rstN)
    exec && cOp == OP_DEV_MAP && !cmdW_q[0][31] |=> !devValid_q[$past(cDev)]) else $error("device unmap ignored");
  a_discard_clr : assert property (@(posedge clk) disable iff (!rstN)
    exec && cOp == OP_DISCARD |=> !itt_q[$past(kProbe)].valid) else $error("discard left mapping");
  a_drop_unmapped : assert property (@(posedge clk) disable iff (!rstN)
    evIn.valid && !devValid_q[evIn.dev] && !exec && ackValid == '0 |=> $stable(pend_q)) else $error("unmapped event delivered");
  a_ack_clears : assert property (@(posedge clk) disable iff (!rstN)
    ackValid[1] && ackId == LPI_FIRST + 32'h1 && !evIn.valid && !exec |=> !pend_q[1][1]) else $error("acknowledge did not clear");
  a_group_ns1 : assert property (@(posedge clk) disable iff (!rstN)
    $past(rstN) |-> irqNsGroup1_q) else $error("group output not Non-secure Group 1");
  a_full_flag : assert property (@(posedge clk) disable iff (!rstN)
    busRd && busAddr == REG_STATUS && wrPtr_q + QPTR_W'(1) == rdPtr_q |=> busRdData_q[1]) else $error("queue full not reported");
endmodule : mit_translate_top

// ==== mit_far_model.sv ====
// mit_far_model: per-router acknowledge source on the far side of the block.
// assumes one clock; the bench asks for an acknowledge by pulsing ackReq.
`timescale 1ns/1ps
module mit_far_model
  import mit_pkg::*;
(
  input  wire logic [0:0]               clk,
  input  wire logic [NUM_RTR-1:0]       ackReq,
  input  wire logic [NUM_RTR-1:0][31:0] irqId_q,
  output logic      [NUM_RTR-1:0]       ackValid_q = '0,
  output logic      [31:0]              ackId_q = '0
);
  always @(posedge clk)
  begin
    ackValid_q <= ackReq;
    // id toggles outside an acknowledge so a stale value never matches
    if (ackReq == '0)
      ackId_q <= ~ackId_q;
    else
      for (int r = 0; r < NUM_RTR; r++)
        if (ackReq[r])
          ackId_q <= irqId_q[r];
  end
endmodule : mit_far_model

// ==== message_interrupt_translation_tb.sv ====
// message_interrupt_translation_tb: register, command and event tests.
// assumes the acknowledge model beside the block and QDEPTH of 8.
`timescale 1ns/1ps
module message_interrupt_translation_tb
  import mit_pkg::*;
;
  logic                       clk = 0;
  logic                       nrst = 0;
  logic [ADDR_W-1:0]          busAddr = '0;
  logic [31:0]                busWrData = '0;
  logic                       busWr = 0;
  logic                       busRd = 0;
  logic [31:0]                busRdData_q;
  logic [31:0]                rdv;
  mit_event_t                 evIn = '0;
  logic [NUM_RTR-1:0]         ackReq = '0;
  logic [NUM_RTR-1:0]         ackValid;
  logic [31:0]                ackId;
  logic [NUM_RTR-1:0]         irqValid_q;
  logic [NUM_RTR-1:0][31:0]   irqId_q;
  logic [NUM_RTR-1:0][7:0]    irqPrio_q;
  logic                       irqNsGroup1_q;
  logic [2:0]                 wp = '0;
  int                         num_errors = 0;
  int                         comparisons = 0;

  mit_translate_top i_mit_translate_top (.clk(clk), .nrst(nrst), .busAddr(busAddr),
    .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData_q(busRdData_q),
    .evIn(evIn), .ackValid(ackValid), .ackId(ackId), .irqValid_q(irqValid_q),
    .irqId_q(irqId_q), .irqPrio_q(irqPrio_q), .irqNsGroup1_q(irqNsGroup1_q));
  mit_far_model i_mit_far_model (.clk(clk), .ackReq(ackReq), .irqId_q(irqId_q),
    .ackValid_q(ackValid), .ackId_q(ackId));

  initial
    forever #5 clk = ~clk;

  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      num_errors++;
    end
  endtask : chk

  // one bus cycle; read data are caught in the single cycle they stand
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    busWr <= w;
    busRd <= !w;
    busAddr <= a;
    busWrData <= d;
    @(posedge clk);
    busWr <= 1'b0;
    busRd <= 1'b0;
    #1 rdv = busRdData_q;
  endtask : acc

  task automatic cmd(input logic [31:0] w0, w1, w2, w3, w4);
    logic [31:0] wd [5];
    wd = '{w0, w1, w2, w3, w4};
    for (int i = 0; i < 5; i++)
      acc(1'b1, ADDR_W'(32'h400 + (int'(wp) * 8 + i) * 4), wd[i]);
    wp = wp + 3'h1;
    acc(1'b1, REG_CMD_WR, 32'(wp));
    // poll at least once, also when the pointer wraps to zero
    rdv = 32'hFFFF_FFFF;
    for (int i = 0; i < 40 && rdv !== 32'(wp); i++)
      acc(1'b0, REG_CMD_RD, 32'h0);
    chk(rdv, 32'(wp));
  endtask : cmd

  task automatic ev(input logic [1:0] d, input logic [1:0] e);
    @(posedge clk);
    evIn <= '{1'b1, d, e};
    @(posedge clk);
    evIn <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : ev

  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1'b0, REG_CFG_BASE, 32'h0);
    chk(rdv, 32'h0000_000D);
    chk(32'(irqNsGroup1_q), 32'h1);
    acc(1'b0, 12'h100, 32'h0);
    chk(rdv, 32'h0);
    acc(1'b1, 12'h804, 32'h0000_00FF);
    acc(1'b0, 12'h804, 32'h0);
    chk(rdv, 32'h0000_00FD);
    acc(1'b1, REG_CTRL, 32'h0000_0002);
    cmd(32'h8000_0101, 32'h0, 32'h0, 32'h0000_2000, 32'h0);
    cmd(32'h0000_0004, 32'h0, 32'h2, 32'h1002_0000, 32'h0);
    cmd(32'h0002_0103, 32'h0000_2001, 32'h2, 32'h0, 32'h0);
    acc(1'b1, REG_CTRL, 32'h0000_0003);
    acc(1'b1, REG_CFG_BASE, 32'h0);
    acc(1'b0, REG_CFG_BASE, 32'h0);
    chk(rdv, 32'h0000_000D);
    ev(2'h1, 2'h2);
    chk(32'(irqValid_q), 32'h2);
    chk(irqId_q[1], 32'h0000_2001);
    chk(32'(irqPrio_q[1]), 32'h0000_00FC);
    @(posedge clk);
    ackReq <= 2'b10;
    @(posedge clk);
    ackReq <= 2'b00;
    repeat (4) @(posedge clk);
    #1 chk(32'(irqValid_q), 32'h0);
    ev(2'h2, 2'h0);
    chk(32'(irqValid_q), 32'h0);
    ev(2'h1, 2'h2);
    cmd(32'h0000_0005, 32'h0, 32'h0, 32'h1002_0000, 32'h1000_0000);
    chk(32'(irqValid_q), 32'h1);
    chk(irqId_q[0], 32'h0000_2001);
    chk(32'(irqPrio_q[0]), 32'h0000_00FC);
    cmd(32'h0002_0107, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(32'(irqValid_q), 32'h0);
    cmd(32'h0000_000A, 32'h0, 32'h0, 32'h0, 32'h0);
    ev(2'h1, 2'h2);
    chk(32'(irqValid_q), 32'h0);
    // collection 3 on router 0 by address, collection 1 on router 1 by number
    cmd(32'h0000_0004, 32'h0, 32'h3, 32'h1000_0000, 32'h0);
    cmd(32'h0002_0103, 32'h0000_2001, 32'h3, 32'h0, 32'h0);
    acc(1'b1, REG_CTRL, 32'h0000_0001);
    cmd(32'h0000_0004, 32'h0, 32'h1, 32'h1, 32'h0);
    cmd(32'h0002_0106, 32'h0, 32'h1, 32'h0, 32'h0);
    ev(2'h1, 2'h2);
    chk(32'(irqValid_q), 32'h2);
    // a table change shows only once the cached copy is dropped
    acc(1'b1, 12'h804, 32'h0);
    ev(2'h1, 2'h2);
    chk(32'(irqValid_q), 32'h2);
    cmd(32'h0002_0108, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(32'(irqValid_q), 32'h0);
    ev(2'h1, 2'h2);
    acc(1'b1, 12'h804, 32'h0000_00F9);
    acc(1'b0, REG_STATUS, 32'h0);
    chk(rdv, 32'h0);
    chk(32'(irqValid_q), 32'h0);
    acc(1'b1, REG_INV_ALL, 32'h0);
    acc(1'b0, 12'h804, 32'h0);
    chk(rdv, 32'h0000_00F9);
    chk(32'(irqValid_q), 32'h2);
    chk(32'(irqPrio_q[1]), 32'h0000_00F8);
    @(posedge clk);
    ackReq <= 2'b10;
    @(posedge clk);
    ackReq <= 2'b00;
    cmd(32'h0000_0101, 32'h0, 32'h0, 32'h0, 32'h0);
    ev(2'h1, 2'h2);
    chk(32'(irqValid_q), 32'h0);
    stop_test();
  end

  initial
  begin
    #100us;
    num_errors++;
    stop_test();
  end
endmodule : message_interrupt_translation_tb
